// File: pkg/fqp_pkg.sv
// Shared constants and types for the quad program / power-down / OTP command block
package fqp_pkg;

  // Core clock period
  localparam int CLK_PERIOD_NS = 8;

  // Command opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_QUAD_PROGRAM = 8'h38;
  localparam logic [7:0] OP_DEEP_PD      = 8'hb9;
  localparam logic [7:0] OP_ENTER_OTP    = 8'hb1;
  localparam logic [7:0] OP_EXIT_OTP     = 8'hc1;
  localparam logic [7:0] OP_READ_SEC     = 8'h2b;
  localparam logic [7:0] OP_WRITE_SEC    = 8'h2f;
  localparam logic [7:0] OP_FAST_READ    = 8'h0b;

  // Frame layout, counted in completed bytes
  localparam logic [2:0] IDX_LAST_ADDR  = 3'h3;
  localparam logic [2:0] IDX_FIRST_DATA = 3'h4;
  localparam logic [2:0] IDX_READ_DATA  = 3'h5;

  // Security register fields and reset
  localparam int         SEC_FACTORY_BIT = 0;
  localparam int         SEC_LOCK_BIT    = 1;
  localparam int         SEC_PSUSP_BIT   = 2;
  localparam int         SEC_ESUSP_BIT   = 3;
  localparam int         SEC_PFAIL_BIT   = 5;
  localparam int         SEC_EFAIL_BIT   = 6;
  localparam logic [7:0] SEC_RESET       = 8'h00;

  // Status register fields and reset
  localparam int         STAT_QUAD_EN_BIT = 6;
  localparam int         STAT_BP_LSB = 2;
  localparam logic [7:0] STAT_RESET  = 8'h00;

  // Memory sizes
  localparam int PAGE_BYTES = 256;
  localparam int OTP_BYTES  = 1024;
  localparam int ARR_BLOCKS = 16;

  // Timing, in ns as given, then in core cycles
  localparam int PD_ENTRY_NS         = 10000;
  localparam int RELEASE_PULSE_NS    = 20;
  localparam int RELEASE_RECOVERY_NS = 35000;
  localparam int PROGRAM_NS          = 1000000;
  localparam int PD_ENTRY_CYC  = (PD_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REL_PULSE_CYC = (RELEASE_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 RELEASE_PULSE_NS / CLK_PERIOD_NS;
  localparam int RECOVERY_CYC  = (RELEASE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROGRAM_CYC   = (PROGRAM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Core sequencer states, Gray along each path out of idle; the returns to idle flip two or three bits
  typedef enum logic [2:0] {
    ST_IDLE       = 3'b000,
    ST_PROG_WAIT  = 3'b001,
    ST_PROG_WRITE = 3'b011,
    ST_PD_ENTRY   = 3'b010,
    ST_PD         = 3'b110,
    ST_PD_RECOVER = 3'b111
  } fqp_state_t;

endpackage

// File: hw/fqp_ram.sv
// Small single-port memory with registered read data
module fqp_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256
) (
  input  logic                     clk,
  input  logic                     we,
  input  logic [$clog2(DEPTH)-1:0] addr,
  input  logic [WIDTH-1:0]         wdata,
  output logic [WIDTH-1:0]         rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Refuse shapes the address port cannot serve
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_shape
    $error("fqp_ram: DEPTH must be at least 2 and WIDTH at least 1");
  end

  // Read returns the old word on a write to the same address
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule // fqp_ram

// File: hw/fqp_cmd.sv
// Command interpreter: quad page program, deep power-down, OTP mode, security readout
//
// Functional notes
// - Quad program takes address and data on four lanes
// - Power-down runs only on byte-aligned select rise
// - Wait entry delay before entering power-down
// - Power-down ignores every command
// - Long select pulse or reset leaves power-down
// - Wait release delay before accepting commands again
// - Enter-OTP redirects accesses to the OTP region
// - In OTP mode reads and programs hit OTP
// - Locked OTP area refuses any update
// - OTP mode rejects status and security writes
// - Enter/exit OTP are opcode-only; exit restores array
// - Security register readable outside power-down, repeated while clocked
// - Security register shifts out on serial output
// - Bit 0 shows factory lock of second area
// - Bit 1 lock is sticky, freezes first area
// - Bit 2 follows program suspend and resume
// - Bit 3 follows erase suspend and resume
// - Bit 5 flags failed program, cleared by success
// - Bit 6 flags failed erase, cleared by success
// - Last 256 bytes kept, wrapping within the page
// - Program starts at select rise, then clears latch
// - Block-protected page is not programmed
module fqp_cmd import fqp_pkg::*; #(
  parameter int       RECOVER_CYC  = RECOVERY_CYC,
  parameter int       PROG_CYC     = PROGRAM_CYC,
  parameter bit       FACTORY_LOCK = 1'b0
) (
  input  logic        core_clk,
  input  logic        sys_rst,
  input  logic        link_clk,
  input  logic        cs_n,
  input  logic [3:0]  data_lanes_in,
  output logic [3:0]  data_lanes_out,
  output logic [3:0]  data_lanes_oe,
  input  logic        prog_suspend,
  input  logic        prog_resume,
  input  logic        erase_suspend,
  input  logic        erase_resume,
  input  logic        erase_done,
  input  logic        erase_failed,
  output logic        arr_wr_en,
  output logic [23:0] arr_addr,
  output logic [7:0]  arr_wdata,
  output logic        otp_mode,
  output logic        deep_powerdown,
  output logic        write_in_progress,
  output logic        write_enable_latch
);

  // Refuse timer lengths the sequencer cannot count
  if (RECOVER_CYC < 1 || PROG_CYC < 1 || REL_PULSE_CYC > 255) begin : g_bad_timing
    $error("fqp_cmd: timer counts out of range");
  end

  // ---------------- Link domain ----------------
  logic       lk_in_frame;
  logic       lk_quad;
  logic [2:0] lk_bits;
  logic [2:0] lk_idx;
  logic [7:0] lk_sh;
  logic [7:0] lk_byte;
  logic [7:0] lk_op;
  logic [7:0] lk_next;
  logic       lk_tog;
  logic       lk_frac;
  logic [7:0] tx_sh;
  logic [10:0] pub;
  logic [7:0] tx_hold;

  // Frame marker: select high clears it, first edge sets it
  always_ff @(posedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      lk_in_frame <= 1'b0;
    end else begin
      lk_in_frame <= 1'b1;
    end
  end

  // Lane width: one lane for the opcode, four after a quad program opcode
  wire       lk_quad_now = lk_in_frame & lk_quad;
  wire [2:0] lk_bits_cur = lk_in_frame ? lk_bits : 3'h0;
  wire [2:0] lk_idx_cur  = lk_in_frame ? lk_idx : 3'h0;
  wire [7:0] lk_sh_nx    = lk_quad_now ? {lk_sh[3:0], data_lanes_in}
                                       : {lk_sh[6:0], data_lanes_in[0]};
  wire [2:0] lk_bits_nx  = lk_bits_cur + (lk_quad_now ? 3'h4 : 3'h1);
  wire       lk_done     = (lk_bits_nx == 3'h0);
  wire       lk_op_done  = lk_done & (lk_idx_cur == 3'h0);

  // Shifter, byte counter and byte toggle toward the core
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lk_sh   <= 8'h00;
      lk_bits <= 3'h0;
      lk_idx  <= 3'h0;
      lk_byte <= 8'h00;
      lk_op   <= 8'h00;
      lk_tog  <= 1'b0;
      lk_quad <= 1'b0;
      lk_frac <= 1'b0;
    end else begin
      lk_sh   <= lk_sh_nx;
      lk_bits <= lk_bits_nx;
      lk_frac <= ~lk_done;
      lk_quad <= lk_op_done ? (lk_sh_nx == OP_QUAD_PROGRAM) : lk_quad_now;
      lk_idx  <= (lk_done && lk_idx_cur != 3'h7) ? lk_idx_cur + 3'h1 : lk_idx_cur;
      if (lk_done) begin
        lk_byte <= lk_sh_nx;
        lk_tog  <= ~lk_tog;
      end
      if (lk_op_done) begin
        lk_op <= lk_sh_nx;
      end
    end
  end

  // Mid-byte copy of the core's prefetch, long after the core updated it
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lk_next <= 8'h00;
    end else if (lk_bits_nx == 3'h4 && !lk_quad_now) begin
      lk_next <= tx_hold;
    end
  end

  // Output selection; pub only changes while select is high
  wire lk_rd_sec = pub[10] & (lk_op == OP_READ_SEC) & (lk_idx != 3'h0);
  wire lk_rd_otp = pub[9] & pub[8] & (lk_op == OP_FAST_READ) & (lk_idx >= IDX_READ_DATA);
  wire lk_tx_on  = lk_in_frame & (lk_rd_sec | lk_rd_otp);
  wire lk_load   = (lk_bits == 3'h0);

  // Serial output on the falling edge; select high releases the lane
  always_ff @(negedge link_clk or posedge sys_rst or posedge cs_n) begin
    if (sys_rst || cs_n) begin
      tx_sh         <= 8'h00;
      data_lanes_oe <= 4'h0;
    end else if (lk_tx_on) begin
      tx_sh         <= lk_load ? (lk_rd_sec ? pub[7:0] : lk_next)
                               : {tx_sh[6:0], 1'b0};
      data_lanes_oe <= 4'h2;
    end else begin
      data_lanes_oe <= 4'h0;
    end
  end

  assign data_lanes_out = {2'b00, tx_sh[7], 1'b0};

  // ---------------- Core domain ----------------
  logic        cs_meta, cs_s, cs_d;
  logic        tog_meta, tog_s, tog_d;
  logic        frac_meta, frac_s;
  fqp_state_t  state;
  logic [31:0] tmr;
  logic [2:0]  bidx;
  logic [7:0]  op;
  logic [23:0] addr;
  logic [7:0]  col;
  logic [7:0]  status;
  logic        lock1, psusp, esusp, pfail, efail;
  logic [7:0]  rel_cnt;
  logic [8:0]  wi;
  logic        w_go;
  logic [7:0]  w_col;
  logic [PAGE_BYTES-1:0] pvalid;
  logic [9:0]  rd_addr;
  logic        pb_we;
  logic [7:0]  pb_rdata;

  // Two-stage synchronisers for select, byte toggle and partial-byte level
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {cs_meta, cs_s, cs_d}    <= 3'b111;
      {tog_meta, tog_s, tog_d} <= 3'b000;
      {frac_meta, frac_s}      <= 2'b00;
    end else begin
      {cs_meta, cs_s, cs_d}    <= {cs_n, cs_meta, cs_s};
      {tog_meta, tog_s, tog_d} <= {lk_tog, tog_meta, tog_s};
      {frac_meta, frac_s}      <= {lk_frac, frac_meta};
    end
  end

  // Frame events; lk_byte is stable for many cycles after its toggle
  wire byte_evt = tog_s ^ tog_d;
  wire cs_rise  = cs_s & ~cs_d;
  wire cs_fall  = ~cs_s & cs_d;
  wire idle     = (state == ST_IDLE);
  wire in_pd    = (state == ST_PD_ENTRY) | (state == ST_PD) | (state == ST_PD_RECOVER);
  wire quad_en  = status[STAT_QUAD_EN_BIT];
  wire [3:0] bp = status[STAT_BP_LSB +: 4];

  // Block protection from the top of the array
  wire [3:0] bp_m1     = bp - 4'h1;
  wire [4:0] first_blk = 5'(ARR_BLOCKS) - (5'h01 << bp_m1[1:0]);
  wire bp_protect = (bp != 4'h0) & ((bp > 4'h4) | ({1'b0, addr[19:16]} >= first_blk));

  // Command decode at a byte-aligned select rise, idle only
  wire cmd_end   = cs_rise & ~frac_s & idle;
  wire one_byte  = (bidx == 3'h1);
  wire do_wen    = cmd_end & one_byte & (op == OP_WRITE_ENABLE);
  wire do_wst    = cmd_end & (bidx == 3'h2) & (op == OP_WRITE_STATUS)
                   & write_enable_latch & ~otp_mode;
  wire do_pdn    = cmd_end & one_byte & (op == OP_DEEP_PD);
  wire do_oin    = cmd_end & one_byte & (op == OP_ENTER_OTP);
  wire do_oout   = cmd_end & one_byte & (op == OP_EXIT_OTP);
  wire do_wrsec  = cmd_end & one_byte & (op == OP_WRITE_SEC)
                   & write_enable_latch & ~otp_mode;
  wire qpp_ok    = cmd_end & (op == OP_QUAD_PROGRAM) & (bidx >= IDX_READ_DATA)
                   & write_enable_latch & quad_en;
  wire otp_lock  = addr[9] ? FACTORY_LOCK : lock1;
  wire qpp_block = otp_mode ? otp_lock : bp_protect;
  wire qpp_go    = qpp_ok & ~qpp_block;
  wire qpp_fail  = qpp_ok & qpp_block;
  wire walk_end  = (state == ST_PROG_WRITE) & wi[8];
  wire tmr_end   = (state == ST_PD_ENTRY)   ? (tmr == 32'(PD_ENTRY_CYC - 1)) :
                   (state == ST_PD_RECOVER) ? (tmr == 32'(RECOVER_CYC - 1)) :
                   (tmr == 32'(PROG_CYC - 1));
  wire rel_ok    = cs_rise & (rel_cnt >= 8'(REL_PULSE_CYC));

  // Next state of the sequencer
  fqp_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (do_pdn) begin
          next_state = ST_PD_ENTRY;
        end else if (qpp_go) begin
          next_state = ST_PROG_WAIT;
        end
      end
      ST_PROG_WAIT:  next_state = tmr_end ? ST_PROG_WRITE : ST_PROG_WAIT;
      ST_PROG_WRITE: next_state = walk_end ? ST_IDLE : ST_PROG_WRITE;
      ST_PD_ENTRY:   next_state = tmr_end ? ST_PD : ST_PD_ENTRY;
      ST_PD:         next_state = rel_ok ? ST_PD_RECOVER : ST_PD;
      ST_PD_RECOVER: next_state = tmr_end ? ST_IDLE : ST_PD_RECOVER;
      default:       next_state = ST_IDLE;
    endcase
  end

  // Sequencer, timer and release-pulse measure
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state   <= ST_IDLE;
      tmr     <= 32'h0;
      rel_cnt <= 8'h00;
    end else begin
      state   <= next_state;
      tmr     <= (next_state != state) ? 32'h0 : tmr + 32'h1;
      rel_cnt <= (cs_s || cs_fall) ? 8'h00 : rel_cnt + {7'h00, rel_cnt != 8'hff};
    end
  end

  // Frame capture: opcode, address, page column; held while busy
  wire cap = byte_evt & idle;
  assign pb_we = cap & (op == OP_QUAD_PROGRAM) & (bidx >= IDX_FIRST_DATA);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bidx <= 3'h0;
      op   <= 8'h00;
      addr <= 24'h0;
      col  <= 8'h00;
    end else if (cs_fall) begin
      bidx <= 3'h0;
    end else if (cap) begin
      bidx <= (bidx == 3'h7) ? bidx : bidx + 3'h1;
      if (bidx == 3'h0) op <= lk_byte;
      if (bidx != 3'h0 && bidx <= IDX_LAST_ADDR) addr <= {addr[15:0], lk_byte};
      if (bidx == IDX_LAST_ADDR) col <= lk_byte;
      if (pb_we) col <= col + 8'h01;
    end
  end

  // Page byte map: later bytes overwrite earlier ones at the wrapped column
  always_ff @(posedge core_clk) begin
    if (sys_rst || (cs_fall && idle)) begin
      pvalid <= '0;
    end else if (pb_we) begin
      pvalid[col] <= 1'b1;
    end
  end

  // Page walk after the program time; one cycle read latency
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wi    <= 9'h000;
      w_go  <= 1'b0;
      w_col <= 8'h00;
    end else begin
      wi    <= (state == ST_PROG_WRITE) ? wi + 9'h001 : 9'h000;
      w_go  <= (state == ST_PROG_WRITE) & ~wi[8];
      w_col <= wi[7:0];
    end
  end

  wire       w_store = w_go & pvalid[w_col];
  wire       otp_we  = w_store & otp_mode;
  wire [9:0] otp_a   = (state == ST_PROG_WRITE) ? {addr[9:8], w_col} : rd_addr;
  wire [7:0] pb_a    = (state == ST_PROG_WRITE) ? wi[7:0] : col;

  fqp_ram #(.WIDTH(8), .DEPTH(PAGE_BYTES)) u_page (
    .clk   (core_clk),
    .we    (pb_we),
    .addr  (pb_a),
    .wdata (lk_byte),
    .rdata (pb_rdata)
  );

  fqp_ram #(.WIDTH(8), .DEPTH(OTP_BYTES)) u_otp (
    .clk   (core_clk),
    .we    (otp_we),
    .addr  (otp_a),
    .wdata (pb_rdata),
    .rdata (tx_hold)
  );

  // OTP read prefetch, one byte ahead of the serial output
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_addr <= 10'h000;
    end else if (cap && otp_mode && op == OP_FAST_READ && bidx >= IDX_LAST_ADDR) begin
      rd_addr <= (bidx == IDX_LAST_ADDR) ? {addr[1:0], lk_byte} : rd_addr + 10'h001;
    end
  end

  // Main-array write port, registered
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      arr_wr_en <= 1'b0;
      arr_addr  <= 24'h0;
      arr_wdata <= 8'h00;
    end else begin
      arr_wr_en <= w_store & ~otp_mode;
      arr_addr  <= {addr[23:8], w_col};
      arr_wdata <= pb_rdata;
    end
  end

  // Write enable latch, status, mode and busy flags
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      write_enable_latch <= 1'b0;
      status             <= STAT_RESET;
      otp_mode           <= 1'b0;
      write_in_progress  <= 1'b0;
      deep_powerdown     <= 1'b0;
    end else begin
      if (do_wen) begin
        write_enable_latch <= 1'b1;
      end else if (do_wst || do_wrsec || qpp_fail || walk_end) begin
        write_enable_latch <= 1'b0;
      end
      if (do_wst) status <= addr[7:0];
      if (do_oin) otp_mode <= 1'b1;
      if (do_oout) otp_mode <= 1'b0;
      write_in_progress <= (next_state == ST_PROG_WAIT) | (next_state == ST_PROG_WRITE);
      deep_powerdown    <= (next_state == ST_PD);
    end
  end

  // Security bits; a set in the same cycle as its clear wins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {efail, pfail, esusp, psusp, lock1} <= 5'h00;
    end else begin
      lock1 <= lock1 | do_wrsec;
      psusp <= prog_suspend | (psusp & ~prog_resume);
      esusp <= erase_suspend | (esusp & ~erase_resume);
      pfail <= qpp_fail | (pfail & ~walk_end);
      efail <= erase_done ? erase_failed : efail;
    end
  end

  // Published snapshot for the link, refreshed only between frames
  wire [7:0] sec = {1'b0, efail, pfail, 1'b0, esusp, psusp, lock1, FACTORY_LOCK};
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pub <= {3'b000, SEC_RESET};
    end else if (cs_s) begin
      pub <= {~in_pd, idle, otp_mode, sec};
    end
  end

  // ---------------- Checks ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_release_pulse;
    (state == ST_PD) && rel_ok;
  endsequence

  sequence s_entry_wait;
    (state == ST_PD_ENTRY) && (tmr == 32'(PD_ENTRY_CYC - 1));
  endsequence

  pd_entry_delay_a: assert property ($rose(deep_powerdown) |-> $past(tmr) == 32'(PD_ENTRY_CYC - 1)) else $error("power-down entered early");
  pd_entry_seq_a: assert property (s_entry_wait |=> deep_powerdown) else $error("power-down entry missed");
  pd_ignores_cmd_a: assert property (in_pd |=> $stable(write_enable_latch) && $stable(otp_mode)) else $error("command ran in power-down");
  pd_release_a: assert property (s_release_pulse |=> state == ST_PD_RECOVER ##1 !deep_powerdown) else $error("release pulse not honoured");
  pd_recover_a: assert property ($fell(state == ST_PD_RECOVER) && !sys_rst |-> $past(tmr) == 32'(RECOVER_CYC - 1)) else $error("recovery delay wrong");
  quad_gate_a: assert property ($rose(write_in_progress) |-> $past(write_enable_latch) && $past(quad_en) && !$past(frac_s)) else $error("quad program started without enables");
  prog_done_a: assert property ($fell(write_in_progress) |-> !write_enable_latch && !pfail) else $error("program end did not clear latch");
  otp_secwrite_a: assert property (otp_mode && !lock1 |=> !lock1) else $error("security write accepted in OTP mode");
  lock_sticky_a: assert property (lock1 |=> lock1) else $error("lock bit cleared");
  reserved_zero_a: assert property (sec[4] == 1'b0 && sec[7] == 1'b0 && pub[4] == 1'b0) else $error("reserved bit set");
  otp_lock_a: assert property (otp_we |-> !(lock1 && !addr[9]) && !(FACTORY_LOCK && addr[9])) else $error("locked OTP area written");

endmodule // fqp_cmd

// File: test/fqp_host.sv
// Host serial flash controller model driving clock, select and lanes
module fqp_host (
  output logic       link_clk,
  output logic       cs_n,
  output logic [3:0] lanes_in,
  input  wire  [3:0] lanes_out,
  input  wire  [3:0] lanes_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] drv;
  logic [7:0] rx;
  // Wire level: device wins on lanes it enables
  assign lanes_in = (lanes_oe & lanes_out) | (~lanes_oe & drv);
  initial begin
    link_clk = 1'b0;
    cs_n = 1'b1;
    drv = 4'h0;
  end
  // Select falls with the clock parked low
  task automatic start();
    #5 cs_n = 1'b0;
  endtask
  // One bit on lane0 or a nibble on all lanes per edge
  task automatic send(input logic [7:0] b, input bit quad, input int n);
    for (int i = 0; i < n; i++) begin
      if (quad)
        drv = b[7-4*i -: 4];
      else
        drv = {3'h0, b[7-i]};
      #32 link_clk = 1'b1;
      rx = {rx[6:0], lanes_in[1]};
      #32 link_clk = 1'b0;
    end
  endtask
  // Released lanes flip so stale values never pass as data
  task automatic stop();
    #32 cs_n = 1'b1;
    drv = ~drv;
    #72;
  endtask
  // Opcode-only frame
  task automatic cmd(input logic [7:0] op);
    start();
    send(op, 1'b0, 8);
    stop();
  endtask
  // Bare select pulse, only after the dwell has passed
  task automatic wake();
    #2000 cs_n = 1'b0;
    #80 cs_n = 1'b1;
    #72;
  endtask
endmodule // fqp_host

// File: test/fqp_cmd_tb.sv
// Self-checking bench for the command interpreter
module fqp_cmd_tb import fqp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RCV = 200;
  logic        core_clk, sys_rst, link_clk, cs_n;
  logic [3:0]  lanes_in, lanes_out, lanes_oe;
  logic [5:0]  ev;
  logic        arr_wr_en, otp_mode, deep_powerdown;
  logic        write_in_progress, write_enable_latch;
  logic [23:0] arr_addr, first_a;
  logic [7:0]  arr_wdata, first_d;
  int          fail_count, num_checks, wr_n;

  fqp_cmd #(.RECOVER_CYC(RCV), .PROG_CYC(50), .FACTORY_LOCK(1'b0)) uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .link_clk(link_clk), .cs_n(cs_n),
    .data_lanes_in(lanes_in), .data_lanes_out(lanes_out), .data_lanes_oe(lanes_oe),
    .prog_suspend(ev[5]), .prog_resume(ev[4]), .erase_suspend(ev[3]),
    .erase_resume(ev[2]), .erase_done(ev[1]), .erase_failed(ev[0]),
    .arr_wr_en(arr_wr_en), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .otp_mode(otp_mode), .deep_powerdown(deep_powerdown),
    .write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch));

  fqp_host host (.link_clk(link_clk), .cs_n(cs_n), .lanes_in(lanes_in),
    .lanes_out(lanes_out), .lanes_oe(lanes_oe));

  always #4 core_clk = ~core_clk;

  // Off-edge capture of the first array write
  always @(negedge core_clk) begin
    if (arr_wr_en === 1'b1) begin
      if (wr_n == 0) begin
        first_a = arr_addr;
        first_d = arr_wdata;
      end
      wr_n++;
    end
  end

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One-cycle event pulse on the core side
  task automatic pulse(input logic [5:0] v);
    ev = v;
    cyc(1);
    ev = 6'h00;
  endtask

  // Two bytes of one read frame must match
  task automatic sec_read(input logic [7:0] exp);
    host.start();
    host.send(OP_READ_SEC, 1'b0, 8);
    host.send(8'h00, 1'b0, 8);
    chk("sec byte", {16'h0, host.rx}, {16'h0, exp});
    host.send(8'h00, 1'b0, 8);
    chk("sec repeat", {16'h0, host.rx}, {16'h0, exp});
    host.stop();
  endtask

  // Quad program of two bytes at a
  task automatic qprog(input logic [23:0] a);
    host.start();
    host.send(OP_QUAD_PROGRAM, 1'b0, 8);
    host.send(a[23:16], 1'b1, 2);
    host.send(a[15:8], 1'b1, 2);
    host.send(a[7:0], 1'b1, 2);
    host.send(8'ha5, 1'b1, 2);
    host.send(8'h3c, 1'b1, 2);
    host.stop();
  endtask

  // Bounded wait on the busy flag
  task automatic wait_wip(input logic v);
    int k;
    k = 0;
    while (write_in_progress !== v && k < 3000) begin
      cyc(1);
      k++;
    end
  endtask

  // Watchdog sized well past the longest sequence
  initial begin
    #400000;
    fail_count++;
    $display("Error watchdog expected done seen timeout");
    give_verdict();
  end

  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    ev = 6'h00;
    cyc(2);
    sys_rst = 1'b0;
    cyc(4);
    sec_read(8'h00);
    qprog(24'h000010);
    cyc(400);
    chk("writes", 24'(wr_n), 24'h0);
    $display("test reset and refusal done");
    host.cmd(OP_WRITE_ENABLE);
    host.start();
    host.send(OP_WRITE_STATUS, 1'b0, 8);
    host.send(8'h40, 1'b0, 8);
    host.stop();
    host.cmd(OP_WRITE_ENABLE);
    cyc(4);
    chk("latch", 24'(write_enable_latch), 24'h1);
    qprog(24'h000010);
    wait_wip(1'b1);
    chk("wip", 24'(write_in_progress), 24'h1);
    wait_wip(1'b0);
    chk("latch clear", 24'(write_enable_latch), 24'h0);
    chk("writes", 24'(wr_n), 24'h2);
    chk("addr", first_a, 24'h000010);
    chk("data", {16'h0, first_d}, 24'h0000a5);
    $display("test quad program done");
    host.cmd(OP_ENTER_OTP);
    cyc(4);
    chk("otp", 24'(otp_mode), 24'h1);
    host.cmd(OP_EXIT_OTP);
    cyc(4);
    chk("otp exit", 24'(otp_mode), 24'h0);
    $display("test otp mode done");
    host.start();
    host.send(OP_DEEP_PD, 1'b0, 8);
    host.send(8'h00, 1'b0, 1);
    host.stop();
    cyc(1300);
    chk("pd misaligned", 24'(deep_powerdown), 24'h0);
    host.cmd(OP_DEEP_PD);
    cyc(1300);
    chk("pd", 24'(deep_powerdown), 24'h1);
    // A command frame in power-down is itself a release pulse, yet ignored
    host.cmd(OP_ENTER_OTP);
    cyc(4);
    chk("pd ignore", 24'(otp_mode), 24'h0);
    chk("pd frame wake", 24'(deep_powerdown), 24'h0);
    host.cmd(OP_ENTER_OTP);
    cyc(4);
    chk("recovery", 24'(otp_mode), 24'h0);
    cyc(RCV);
    host.cmd(OP_ENTER_OTP);
    cyc(4);
    chk("recovered", 24'(otp_mode), 24'h1);
    host.cmd(OP_EXIT_OTP);
    host.cmd(OP_DEEP_PD);
    cyc(1300);
    chk("pd again", 24'(deep_powerdown), 24'h1);
    host.wake();
    chk("pd wake", 24'(deep_powerdown), 24'h0);
    cyc(RCV);
    $display("test power-down done");
    pulse(6'b101000);
    sec_read(8'h0c);
    pulse(6'b000011);
    sec_read(8'h4c);
    pulse(6'b010100);
    sec_read(8'h40);
    pulse(6'b000010);
    sec_read(8'h00);
    host.cmd(OP_WRITE_ENABLE);
    host.cmd(OP_WRITE_SEC);
    sec_read(8'h02);
    $display("test status flags done");
    give_verdict();
  end
endmodule // fqp_cmd_tb
